// [verilog/ntbptc_pkg.sv]
/*
  Package for the bridge configuration tunnel: register map, field
  positions, reset values, completion codes, state and register types.
  Assumes an APB slave port with 12-bit byte addresses, 32-bit data.
*/
// Functional notes
// R01 - Dword and extended index from control fields
// R02 - Request addressed by bus, slot, function fields
// R03 - Kind bit selects type 0 or 1
// R04 - Operation bit selects read or write
// R05 - Each payload write launches one transaction; the code ignores payload writes while the tunnel is not idle
// R06 - Request byte enables copy payload write strobes
// R07 - Write operation sends written payload value
// R08 - Read ignores written value, returns data there
// R09 - Outcome reported in state register
// R10 - Address, operation, payload cleared only at power-up
// R11 - Busy bit high while transaction in flight
// R12 - Done flag set; write one clears or aborts
// R13 - Completion code in bits 4:2 while done
// R14 - Aborted flag held until next launch
// R15 - Software waits for idle before next launch
package ntbptc_pkg;

  localparam logic [11:0] OFS_CTRL     = 12'h0A0;
  localparam logic [11:0] OFS_DATA     = 12'h0A4;
  localparam logic [11:0] OFS_STATE    = 12'h0A8;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h0C0;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h0C4;

  localparam int DW_IDX_LSB  = 2;
  localparam int EXT_IDX_LSB = 8;
  localparam int FN_LSB      = 12;
  localparam int SLOT_LSB    = 15;
  localparam int BUS_LSB     = 20;
  localparam int KIND_BIT    = 30;
  localparam int RW_BIT      = 31;

  localparam int BUSY_BIT    = 0;
  localparam int DONE_BIT    = 1;
  localparam int CODE_LSB    = 2;
  localparam int ABORTED_BIT = 5;
  localparam int CAP_BIT     = 31;

  localparam logic [31:0] CTRL_WMASK = 32'hCFFF_FFFC;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam logic [1:0]  MASK_RST   = 2'h0;

  localparam logic [2:0] CPL_SC  = 3'h0;
  localparam logic [2:0] CPL_UR  = 3'h1;
  localparam logic [2:0] CPL_CRS = 3'h2;
  localparam logic [2:0] CPL_CA  = 3'h3;
  localparam logic [2:0] CPL_RA  = 3'h4;

  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ABORTED = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10
  } ntbptc_state_e;

  typedef struct packed {
    logic [31:0]   ctrl;
    logic [31:0]   data;
    logic [3:0]    be;
    logic          busy;
    logic          done;
    logic [2:0]    code;
    logic          aborted;
    ntbptc_state_e fsm;
    logic          req_valid;
    logic          abort_pulse;
    logic [1:0]    irq_stat;
    logic [1:0]    irq_mask;
    logic          irq;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } ntbptc_regs_s;

endpackage

// [verilog/ntbptc_top.sv]
/*
  Configuration tunnel through the bridge: APB register file, request
  launcher toward the far side and completion capture.
  Assumes far-side request and completion ports on the same clock, a
  power-up reset por and a hot/fundamental reset rst, both synchronous.
*/
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module ntbptc_top
  import ntbptc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  output logic             cfg_req_valid,
  input  wire logic        cfg_req_ready,
  output logic             cfg_req_write,
  output logic             cfg_req_type1,
  output logic [7:0]       cfg_req_bus,
  output logic [4:0]       cfg_req_slot,
  output logic [2:0]       cfg_req_fn,
  output logic [3:0]       cfg_req_ext_idx,
  output logic [5:0]       cfg_req_dw_idx,
  output logic [3:0]       cfg_req_be,
  output logic [31:0]      cfg_req_wdata,
  output logic             cfg_abort,
  input  wire logic        cfg_cpl_valid,
  input  wire logic [2:0]  cfg_cpl_status,
  input  wire logic [31:0] cfg_cpl_rdata
);

  ntbptc_regs_s q;
  ntbptc_regs_s d;
  ntbptc_regs_s hot;
  logic         wr;
  logic         idle;
  logic         launch;
  logic         complete;
  logic         clr_done;
  logic [1:0]   ev;
  logic [31:0]  state_word;

  always_comb begin
    hot        = '0;
    ev         = '0;
    state_word = '0;
    d          = q;
    d.pready      = 1'b0;
    d.abort_pulse = 1'b0;
    idle     = (q.fsm == ST_IDLE);
    wr       = psel & penable & q.pready & pwrite;
    complete = (q.fsm == ST_WAIT) & cfg_cpl_valid;
    launch   = wr & (paddr == OFS_DATA) & idle;             // see R05 R15
    clr_done = wr & (paddr == OFS_STATE) & pstrb[0] & pwdata[DONE_BIT];

    state_word[BUSY_BIT]            = q.busy;               // see R11
    state_word[DONE_BIT]            = q.done;
    state_word[CODE_LSB +: 3]       = q.code;               // see R09 R13
    state_word[ABORTED_BIT]         = q.aborted;
    state_word[CAP_BIT]             = 1'b1;

    // Read data is captured as the access phase opens
    if (psel & penable & ~q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      unique case (paddr)
        OFS_CTRL:     d.prdata = q.ctrl;
        OFS_DATA:     d.prdata = q.data;
        OFS_STATE:    d.prdata = state_word;
        OFS_IRQ_STAT: d.prdata = {30'h0, q.irq_stat};
        OFS_IRQ_MASK: d.prdata = {30'h0, q.irq_mask};
        default:      d.pslverr = 1'b1;
      endcase
    end

    // Target fields are frozen while a transaction is in flight
    if (wr & (paddr == OFS_CTRL) & idle) begin              // see R15
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          d.ctrl[8*b +: 8] = pwdata[8*b +: 8] & CTRL_WMASK[8*b +: 8];
        end
      end
    end
    if (wr & (paddr == OFS_IRQ_MASK) & pstrb[0]) begin
      d.irq_mask = pwdata[1:0];
    end

    if (launch) begin
      if (q.ctrl[RW_BIT]) begin
        d.data = pwdata;                                    // see R07 R08
      end
      d.be        = pstrb;                                  // see R06
      d.fsm       = ST_REQ;
      d.req_valid = 1'b1;
      d.busy      = 1'b1;
      d.done      = 1'b0;
      d.aborted   = 1'b0;                                   // see R14
    end

    // Writing one to done clears it when idle, aborts when busy
    if (clr_done) begin                                     // see R12
      if (q.busy) begin
        d.fsm         = ST_IDLE;
        d.req_valid   = 1'b0;
        d.busy        = 1'b0;
        d.done        = 1'b1;
        d.code        = CPL_RA;
        d.aborted     = 1'b1;
        d.abort_pulse = ~complete;
        ev            = 2'b11;
      end else begin
        d.done = 1'b0;
      end
    end

    unique case (q.fsm)
      ST_IDLE: begin
      end
      ST_REQ: begin
        if (cfg_req_ready & q.req_valid & ~clr_done) begin
          d.req_valid = 1'b0;
          d.fsm       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A completion outranks a same-cycle clear or abort
        if (cfg_cpl_valid) begin                            // see R12
          d.fsm     = ST_IDLE;
          d.busy    = 1'b0;                                 // see R11
          d.done    = 1'b1;
          d.code    = cfg_cpl_status;                       // see R13
          d.aborted = (cfg_cpl_status == CPL_RA);           // see R14
          if (~q.ctrl[RW_BIT]) begin
            d.data = cfg_cpl_rdata;                         // see R08
          end
          ev[IRQ_DONE]    = 1'b1;
          ev[IRQ_ABORTED] = (cfg_cpl_status == CPL_RA);
        end
      end
    endcase

    if (wr & (paddr == OFS_IRQ_STAT) & pstrb[0]) begin
      d.irq_stat = q.irq_stat & ~pwdata[1:0];
    end
    d.irq_stat = d.irq_stat | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);

    // Hot reset keeps target fields, operation, payload and done, but clears kind
    if (rst) begin                                          // see R10
      hot.ctrl     = q.ctrl;
      hot.ctrl[KIND_BIT] = 1'b0;
      hot.data     = q.data;
      hot.done     = q.done;
      hot.irq_mask = MASK_RST;
      hot.fsm      = ST_IDLE;
      d            = hot;
    end
    if (por) begin                                          // see R10
      d      = '0;
      d.ctrl = CTRL_RST;
      d.data = DATA_RST;
      d.fsm  = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign pready          = q.pready;
  assign prdata          = q.prdata;
  assign pslverr         = q.pslverr;
  assign irq             = q.irq;
  assign cfg_req_valid   = q.req_valid;
  assign cfg_req_write   = q.ctrl[RW_BIT];                  // see R04
  assign cfg_req_type1   = q.ctrl[KIND_BIT];                // see R03
  assign cfg_req_bus     = q.ctrl[BUS_LSB +: 8];            // see R02
  assign cfg_req_slot    = q.ctrl[SLOT_LSB +: 5];           // see R02
  assign cfg_req_fn      = q.ctrl[FN_LSB +: 3];             // see R02
  assign cfg_req_ext_idx = q.ctrl[EXT_IDX_LSB +: 4];        // see R01
  assign cfg_req_dw_idx  = q.ctrl[DW_IDX_LSB +: 6];         // see R01
  assign cfg_req_be      = q.be;
  assign cfg_req_wdata   = q.data;
  assign cfg_abort       = q.abort_pulse;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || por);

  sequence seq_launch;
    psel && penable && pready && pwrite && paddr == OFS_DATA
      && q.fsm == ST_IDLE;
  endsequence

  sequence seq_finish;
    q.fsm == ST_WAIT && cfg_cpl_valid;
  endsequence

  chk_launch_request: assert property ( // see R05
    seq_launch |=> cfg_req_valid && q.busy && !q.done)
    else $error("payload write did not launch a request");

  chk_strobe_copy: assert property ( // see R06
    seq_launch |=> cfg_req_be == $past(pstrb))
    else $error("request byte enables differ from write strobes");

  chk_write_payload: assert property ( // see R07
    seq_launch ##0 cfg_req_write |=> cfg_req_wdata == $past(pwdata))
    else $error("write payload not forwarded");

  chk_read_return: assert property ( // see R08
    seq_finish ##0 !cfg_req_write |=> q.data == $past(cfg_cpl_rdata))
    else $error("read data not returned in payload register");

  chk_busy_flight: assert property ( // see R11
    seq_launch |=> q.busy throughout (##[0:3] q.fsm != ST_IDLE))
    else $error("busy low while request in flight");

  chk_done_code: assert property ( // see R12 R13
    seq_finish |=> q.done && !q.busy && q.code == $past(cfg_cpl_status))
    else $error("completion not reported");

  chk_aborted_flag: assert property ( // see R14
    q.done && q.code == CPL_RA |-> q.aborted)
    else $error("requester abort without aborted flag");

  chk_type_select: assert property ( // see R03
    psel && penable && pready && pwrite && paddr == OFS_CTRL
      && q.fsm == ST_IDLE && pstrb[3]
      |=> cfg_req_type1 == $past(pwdata[KIND_BIT]))
    else $error("kind bit not applied to request type");

  chk_frozen_target: assert property ( // see R15
    q.busy && $past(q.busy) |-> $stable(q.ctrl))
    else $error("target fields changed during a transaction");

endmodule

// [tb/ntbptc_far.sv]
/*
  Far-side configuration target: takes a request, answers later.
  Assumes the tunnel request and completion ports share clk.
*/
`timescale 1ns/10ps
module ntbptc_far (
  input  wire logic        clk,
  input  wire logic        req_valid,
  input  wire logic        abort,
  input  wire logic [7:0]  lat,
  input  wire logic [2:0]  sts,
  input  wire logic [31:0] rd,
  output logic             req_ready = 1'b0,
  output logic             cpl_valid = 1'b0,
  output logic [2:0]       cpl_status = 3'h0,
  output logic [31:0]      cpl_rdata = 32'h0
);
  logic       act = 1'b0;
  logic [7:0] cnt = 8'h00;
  always @(posedge clk) begin
    req_ready <= 1'b0;
    cpl_valid <= 1'b0;
    // Idle completion lines keep changing
    cpl_status <= ~cpl_status;
    cpl_rdata <= ~cpl_rdata;
    if (abort) begin
      act <= 1'b0;
      cnt <= 8'h00;
    end else if (req_valid && !act && !req_ready) begin
      cnt <= cnt + 8'h01;
      if (cnt == lat) begin
        req_ready <= 1'b1;
        act <= 1'b1;
        cnt <= 8'h00;
      end
    end else if (act) begin
      cnt <= cnt + 8'h01;
      if (cnt == lat) begin
        cpl_valid <= 1'b1;
        cpl_status <= sts;
        cpl_rdata <= rd;
        act <= 1'b0;
        cnt <= 8'h00;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
/*
  Self-checking bench for the configuration tunnel over APB.
  Assumes the far-side model ntbptc_far on the request port.
*/
`timescale 1ns/10ps
module tb_top;
  import ntbptc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  pst = 4'h0;
  logic [7:0]  lat = 8'h02;
  logic [2:0]  sts = 3'h0;
  logic [31:0] rd = 32'h0;
  logic        rdy, err, se, irq, rv, rr, rw, t1, ab, cv;
  logic [31:0] prd, rdv, wd, crd;
  logic [7:0]  bus;
  logic [4:0]  slot;
  logic [2:0]  fn, cs;
  logic [3:0]  ext, be;
  logic [5:0]  dw;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_abort = 0;
  ntbptc_top dut_u (.clk(clk), .rst(rst), .por(por), .psel(psel),
    .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd), .pstrb(pst),
    .pready(rdy), .prdata(prd), .pslverr(se), .irq(irq),
    .cfg_req_valid(rv), .cfg_req_ready(rr), .cfg_req_write(rw),
    .cfg_req_type1(t1), .cfg_req_bus(bus), .cfg_req_slot(slot),
    .cfg_req_fn(fn), .cfg_req_ext_idx(ext), .cfg_req_dw_idx(dw),
    .cfg_req_be(be), .cfg_req_wdata(wd), .cfg_abort(ab),
    .cfg_cpl_valid(cv), .cfg_cpl_status(cs), .cfg_cpl_rdata(crd));
  ntbptc_far far_u (.clk(clk), .req_valid(rv), .abort(ab), .lat(lat),
    .sts(sts), .rd(rd), .req_ready(rr), .cpl_valid(cv),
    .cpl_status(cs), .cpl_rdata(crd));
  // Counts cycles in which the abort pulse stands
  always @(posedge clk) begin
    if (ab === 1'b1) begin
      n_abort++;
    end
  end
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    pen <= 1'b0;
    @(posedge clk);
    pen <= 1'b1;
    // Wait states end only when pready is seen; the watchdog bounds this
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdv = prd;
    err = se;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(string s, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(s, e, rdv);
  endtask
  // Software polls for done before the next launch
  task automatic wait_done;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATE, 32'h0, 4'h0);
      k++;
    end while (rdv[DONE_BIT] !== 1'b1 && k < 100);
    if (rdv[DONE_BIT] !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED done poll exp 1 got 0");
    end
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rdchk("ctrl", OFS_CTRL, CTRL_RST);
    rdchk("data", OFS_DATA, DATA_RST);
    rdchk("state", OFS_STATE, 32'h8000_0000);
    apb(1'b0, 12'h0B0, 32'h0, 4'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, OFS_IRQ_MASK, 32'h3, 4'hF);
    lat <= 8'h14;
    apb(1'b1, OFS_CTRL, 32'hCA59_E9B4, 4'hF);
    rdchk("ctrl", OFS_CTRL, 32'hCA59_E9B4);
    apb(1'b1, OFS_DATA, 32'h1234_5678, 4'h5);
    rdchk("busy", OFS_STATE, 32'h8000_0001);
    chk("valid", 32'h1, {31'h0, rv});
    chk("fields", 32'h0E96_7A6D,
        {4'h0, rw, t1, bus, slot, fn, ext, dw});
    chk("be", 32'h5, {28'h0, be});
    chk("wdata", 32'h1234_5678, wd);
    wait_done();
    chk("state", 32'h8000_0002, rdv);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("irqst", OFS_IRQ_STAT, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1, 4'h1);
    rdchk("irqclr", OFS_IRQ_STAT, 32'h0);
    $display("test write done");
    apb(1'b1, OFS_IRQ_MASK, 32'h2, 4'hF);
    apb(1'b1, OFS_CTRL, 32'h4A59_E9B4, 4'hF);
    lat <= 8'h02;
    // Last pass returns requester abort, which raises the aborted flag
    for (int i = 0; i < 5; i++) begin
      sts <= 3'(i);
      rd <= 32'hC0DE_0000 + 32'(i);
      apb(1'b1, OFS_DATA, 32'hFFFF_FFFF, 4'hF);
      wait_done();
      chk("code", 32'h8000_0002 | 32'(i << 2)
          | (i == 4 ? 32'h20 : 32'h0), rdv);
      chk("irq", {31'h0, i == 4}, {31'h0, irq});
      rdchk("rdata", OFS_DATA, 32'hC0DE_0000 + 32'(i));
    end
    apb(1'b1, OFS_IRQ_STAT, 32'h2, 4'h1);
    rdchk("irqst", OFS_IRQ_STAT, 32'h1);
    chk("masked", 32'h0, {31'h0, irq});
    $display("test read done");
    lat <= 8'hC8;
    sts <= CPL_SC;
    apb(1'b1, OFS_DATA, 32'h0, 4'hF);
    apb(1'b1, OFS_CTRL, 32'h0, 4'hF);
    apb(1'b1, OFS_STATE, 32'h2, 4'h1);
    rdchk("abort", OFS_STATE, 32'h8000_0032);
    chk("irq", 32'h1, {31'h0, irq});
    chk("abort pulse", 32'h1, n_abort);
    apb(1'b1, OFS_STATE, 32'h2, 4'h1);
    chk("noreq", 32'h0, {31'h0, rv});
    apb(1'b0, OFS_STATE, 32'h0, 4'h0);
    chk("clr", 32'h20, rdv & 32'h22);
    lat <= 8'h02;
    apb(1'b1, OFS_DATA, 32'h0, 4'hF);
    wait_done();
    chk("next", 32'h8000_0002, rdv);
    $display("test abort done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("hot", OFS_CTRL, 32'h0A59_E9B4);
    rdchk("hotd", OFS_DATA, 32'hC0DE_0004);
    por <= 1'b1;
    repeat (2) @(posedge clk);
    por <= 1'b0;
    rdchk("por", OFS_CTRL, CTRL_RST);
    rdchk("pord", OFS_DATA, DATA_RST);
    $display("test reset kinds done");
    finish_test();
  end
endmodule
